/* dca_pkg.sv */
// dca_pkg.sv: register map, field layout and types of the channel mode arbiter.
// Assumes a 32-bit AXI4-Lite slave with 8-bit byte addresses and four channels.
// Behaviour
// R1 - A unit between an acknowledged device and a mapped device starts only on an external request.
// R2 - External memory or mapped device units take external, auto or timer requests only.
// R3 - A peripheral request source must itself be the unit's source or destination.
// R4 - A channel requested by a peripheral port runs only in cycle-steal mode.
// R5 - A unit touching an on-chip register uses 8, 16 or 32 bits, never 128.
// R6 - External request pins start channels 0 and 1 only.
// R7 - A higher channel that requests during a lower burst takes the next unit at once.
// R8 - Under fixed priority a preempted channel 1 waits until channel 0 has no work left.
// R9 - Under round-robin a preempted channel 1 resumes after one unit of channel 0.
// R10 - Under round-robin the two active channels then alternate unit by unit.
// R11 - While a burst channel stays active the CPU never gets the bus between units.
// R12 - When the last channel stops, the bus returns to the CPU at the next boundary.
`default_nettype none
package dca_pkg;
	localparam int NCH        = 4;
	localparam int CNT_W      = 16;
	localparam int FIFO_DEPTH = 16;

	localparam logic [7:0] ADDR_CTRL    = 8'h00;
	localparam logic [7:0] ADDR_STAT    = 8'h04;
	localparam logic [7:0] ADDR_CH_BASE = 8'h10;
	localparam logic [7:0] ADDR_CH_STEP = 8'h08;
	localparam logic [7:0] ADDR_CNT_OFS = 8'h04;

	localparam int CTRL_EN_BIT   = 0;
	localparam int CTRL_RR_BIT   = 1;
	localparam int STAT_DONE_LSB = 0;
	localparam int STAT_ERR_LSB  = 8;
	localparam int STAT_BUSY_BIT = 16;
	localparam int STAT_OWN_LSB  = 17;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		SRC_EXT = 3'h0, SRC_AUTO = 3'h1, SRC_CMP_TIMER = 3'h2,
		SRC_IR = 3'h3, SRC_FSP = 3'h4, SRC_ADC = 3'h5
	} dca_src_type;

	// Peripheral endpoints sit one code above their request source
	typedef enum logic [2:0] {
		EP_ACKDEV = 3'h0, EP_XMEM = 3'h1, EP_MMDEV = 3'h2, EP_ONCHIP = 3'h3,
		EP_IR = 3'h4, EP_FSP = 3'h5, EP_ADC = 3'h6
	} dca_ep_type;

	typedef enum logic [1:0] {SZ_8 = 2'h0, SZ_16 = 2'h1, SZ_32 = 2'h2, SZ_128 = 2'h3} dca_size_type;

	typedef enum logic {ARB_IDLE = 1'h0, ARB_UNIT = 1'h1} dca_arb_type;

	typedef struct packed {
		dca_size_type size;
		dca_ep_type   dst;
		dca_ep_type   src;
		dca_src_type  req;
		logic         burst;
		logic         en;
	} dca_cfg_type;

	typedef struct packed {
		logic [1:0]  ch;
		dca_cfg_type cfg;
	} dca_unit_type;

	typedef struct packed {
		logic [1:0]   ch;
		dca_size_type size;
		logic         burst;
	} dca_log_type;

	localparam logic [1:0]       CTRL_RST = 2'h0;
	localparam dca_cfg_type      CFG_RST  = dca_cfg_type'(13'h0000);
	localparam logic [CNT_W-1:0] CNT_RST  = 16'h0000;

	function automatic logic [7:0] ch_addr(input int i);
		return 8'(ADDR_CH_BASE + 8'(i) * ADDR_CH_STEP);
	endfunction
endpackage
`default_nettype wire

/* dca_cfg_check.sv */
// dca_cfg_check.sv: legality of one channel's request source, bus mode and size.
// Assumes the configuration word comes straight from a register on the same clock.
`timescale 1ns/1ps
`default_nettype none
module dca_cfg_check #(
	parameter int CH = 0
)(
	input  wire dca_pkg::dca_cfg_type cfg,
	output logic                      legal
);
	import dca_pkg::*;

	logic ack_dev;
	logic on_chip;
	logic periph;
	logic code_bad;

	always_comb begin
		ack_dev  = cfg.src == EP_ACKDEV || cfg.dst == EP_ACKDEV;
		on_chip  = cfg.src >= EP_ONCHIP || cfg.dst >= EP_ONCHIP;
		periph   = cfg.req inside {SRC_IR, SRC_FSP, SRC_ADC};
		code_bad = cfg.src > EP_ADC || cfg.dst > EP_ADC || cfg.req > SRC_ADC;
		legal    = !code_bad;
		if (ack_dev && cfg.req != SRC_EXT)
			legal = 1'h0; // R1
		if (!ack_dev && !on_chip && periph)
			legal = 1'h0; // R2
		if (periph && cfg.src != dca_ep_type'(cfg.req + 3'h1)
				&& cfg.dst != dca_ep_type'(cfg.req + 3'h1))
			legal = 1'h0; // R3
		if (periph && cfg.burst)
			legal = 1'h0; // R4
		if (on_chip && cfg.size == SZ_128)
			legal = 1'h0; // R5
		// Pins exist for the two lowest channels only
		if (cfg.req == SRC_EXT && CH > 1)
			legal = 1'h0; // R6
	end
endmodule
`default_nettype wire

/* dca_fifo.sv */
// dca_fifo.sv: first-in first-out buffer with a registered output stage.
// Assumes one clock; capacity is DEPTH words plus the output register.
`timescale 1ns/1ps
`default_nettype none
module dca_fifo #(
	parameter int WIDTH = 5,
	parameter int DEPTH = 16
)(
	input  wire logic             aclk,
	input  wire logic             aresetn,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0]               wr;
		logic [AW-1:0]               rd;
		logic [AW:0]                 cnt;
		logic                        ov;
		logic [WIDTH-1:0]            od;
	} dca_fifo_st_type;

	dca_fifo_st_type f_reg;
	dca_fifo_st_type f_next;
	logic            push;
	logic            pop;

	// Explicit wrap keeps depths that are not powers of two correct
	function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
		return (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'h1);
	endfunction

	always_comb begin
		in_ready = f_reg.cnt != (AW+1)'(DEPTH);
		push     = in_valid && in_ready;
		pop      = f_reg.cnt != '0 && (!f_reg.ov || out_ready);
		f_next   = f_reg;
		if (f_reg.ov && out_ready)
			f_next.ov = 1'h0;
		if (pop) begin
			f_next.od = f_reg.mem[f_reg.rd];
			f_next.ov = 1'h1;
			f_next.rd = bump(f_reg.rd);
		end
		if (push) begin
			f_next.mem[f_reg.wr] = in_data;
			f_next.wr            = bump(f_reg.wr);
		end
		f_next.cnt = f_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			f_reg <= '0;
		else
			f_reg <= f_next;
	end

	assign out_valid = f_reg.ov;
	assign out_data  = f_reg.od;
endmodule
`default_nettype wire

/* dca_arbiter.sv */
// dca_arbiter.sv: four-channel mode checker and bus arbiter with AXI4-Lite registers.
// Assumes the system bus pulses unit_done once per granted unit; pins are asynchronous.
//
// The AXI4-Lite register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module dca_arbiter #(
	parameter int FIFO_DEPTH_P = dca_pkg::FIFO_DEPTH
)(
	input  wire logic                 aclk,
	input  wire logic                 aresetn,
	input  wire logic                 s_axi_awvalid,
	output logic                      s_axi_awready,
	input  wire logic [7:0]           s_axi_awaddr,
	input  wire logic                 s_axi_wvalid,
	output logic                      s_axi_wready,
	input  wire logic [31:0]          s_axi_wdata,
	input  wire logic [3:0]           s_axi_wstrb,
	output logic                      s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	output logic      [1:0]           s_axi_bresp,
	input  wire logic                 s_axi_arvalid,
	output logic                      s_axi_arready,
	input  wire logic [7:0]           s_axi_araddr,
	output logic                      s_axi_rvalid,
	input  wire logic                 s_axi_rready,
	output logic      [31:0]          s_axi_rdata,
	output logic      [1:0]           s_axi_rresp,
	input  wire logic [1:0]           ext_req_n,
	input  wire logic                 cmp_timer_req,
	input  wire logic [2:0]           periph_req,
	output logic                      unit_valid,
	output dca_pkg::dca_unit_type     unit_info,
	input  wire logic                 unit_done,
	output logic                      cpu_grant,
	output logic      [1:0]           transfer_ack_out,
	output logic                      log_valid,
	input  wire logic                 log_ready,
	output dca_pkg::dca_log_type      log_data
);
	import dca_pkg::*;

	typedef struct packed {
		logic                        ctrl_en;
		logic                        ctrl_rr;
		dca_cfg_type [NCH-1:0]       cfg;
		logic [NCH-1:0][CNT_W-1:0]   cnt;
		logic [NCH-1:0]              done;
		logic [NCH-1:0]              err;
		logic [1:0]                  sy1;
		logic [1:0]                  sy2;
		dca_arb_type                 arb;
		logic                        fin;
		logic [1:0]                  rr_ptr;
		logic                        unit_valid;
		dca_unit_type                unit;
		logic [1:0]                  ack;
		logic                        cpu_grant;
		logic                        aw_have;
		logic [7:0]                  aw_addr;
		logic                        w_have;
		logic [31:0]                 w_data;
		logic [3:0]                  w_strb;
		logic                        bvalid;
		logic [1:0]                  bresp;
		logic                        rvalid;
		logic [31:0]                 rdata;
		logic [1:0]                  rresp;
	} dca_state_type;

	localparam int LOG_W = $bits(dca_log_type);

	dca_state_type    s_reg;
	dca_state_type    s_next;
	logic [NCH-1:0]   legal;
	logic [NCH-1:0]   trig;
	logic [NCH-1:0]   req_v;
	logic [NCH-1:0]   req_after;
	logic [NCH-1:0]   burst_v;
	logic [1:0]       owner;
	logic             fin_now;
	logic             chain;
	logic             go_idle;
	logic             go;
	logic [1:0]       go_ch;
	logic             fifo_in_ready;
	dca_log_type      log_rec;
	logic [LOG_W-1:0] fifo_out;

	for (genvar g = 0; g < NCH; g++) begin : g_chk
		dca_cfg_check #(
			.CH(g)
		) u_chk (
			.cfg   (s_reg.cfg[g]),
			.legal (legal[g])
		);
	end

	// Completed units are logged; a full log stalls the arbiter
	dca_fifo #(
		.WIDTH(LOG_W),
		.DEPTH(FIFO_DEPTH_P)
	) u_log (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.in_valid  (fin_now),
		.in_ready  (fifo_in_ready),
		.in_data   (log_rec),
		.out_valid (log_valid),
		.out_ready (log_ready),
		.out_data  (fifo_out)
	);

	// First set bit at or after the start index, wrapping
	function automatic logic [1:0] pick(input logic [NCH-1:0] m, input logic [1:0] from);
		logic [1:0] c;
		logic [1:0] r;
		r = from;
		for (int k = NCH - 1; k >= 0; k--) begin
			c = 2'(from + 2'(k));
			if (m[c])
				r = c;
		end
		return r;
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
			input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (be[b])
				r[8*b +: 8] = d[8*b +: 8];
		end
		return r;
	endfunction

	// Bit 32 marks a mapped address
	function automatic logic [32:0] rd_word(input dca_state_type st, input logic [7:0] a);
		logic [32:0] r;
		r = '0;
		if (a == ADDR_CTRL) begin
			r[32]          = 1'h1;
			r[CTRL_EN_BIT] = st.ctrl_en;
			r[CTRL_RR_BIT] = st.ctrl_rr;
		end
		if (a == ADDR_STAT) begin
			r[32]                  = 1'h1;
			r[STAT_DONE_LSB +: NCH] = st.done;
			r[STAT_ERR_LSB +: NCH]  = st.err;
			r[STAT_BUSY_BIT]        = st.arb == ARB_UNIT;
			r[STAT_OWN_LSB +: 2]    = st.unit.ch;
		end
		for (int i = 0; i < NCH; i++) begin
			if (a == ch_addr(i))
				r = {1'h1, 32'(st.cfg[i])};
			if (a == 8'(ch_addr(i) + ADDR_CNT_OFS))
				r = {1'h1, 32'(st.cnt[i])};
		end
		return r;
	endfunction

	always_comb begin
		trig    = '0;
		req_v   = '0;
		burst_v = '0;
		for (int i = 0; i < NCH; i++) begin
			unique case (s_reg.cfg[i].req)
				SRC_EXT:       trig[i] = (i < 2) && !s_reg.sy2[i % 2]; // R6
				SRC_AUTO:      trig[i] = 1'h1;
				SRC_CMP_TIMER: trig[i] = cmp_timer_req;
				SRC_IR:        trig[i] = periph_req[0];
				SRC_FSP:       trig[i] = periph_req[1];
				SRC_ADC:       trig[i] = periph_req[2];
				default:       trig[i] = 1'h0;
			endcase
			req_v[i] = s_reg.ctrl_en && s_reg.cfg[i].en && legal[i] && !s_reg.err[i]
				&& s_reg.cnt[i] != '0 && trig[i];
			burst_v[i] = s_reg.cfg[i].burst;
		end
		owner     = s_reg.unit.ch;
		req_after = req_v;
		if (s_reg.cnt[owner] == CNT_W'(1))
			req_after[owner] = 1'h0;
		fin_now = s_reg.arb == ARB_UNIT && (unit_done || s_reg.fin) && fifo_in_ready;
		// Burst keeps the bus across unit boundaries
		chain   = fin_now && (req_after & burst_v) != '0; // R11
		go_idle = s_reg.arb == ARB_IDLE && req_v != '0;
		go      = go_idle || chain;
		if (go_idle)
			go_ch = pick(req_v, s_reg.ctrl_rr ? s_reg.rr_ptr : 2'h0);
		else
			go_ch = pick(req_after, s_reg.ctrl_rr ? 2'(owner + 2'h1) : 2'h0); // R7 R8 R9 R10
		log_rec = '{ch: owner, size: s_reg.unit.cfg.size, burst: s_reg.unit.cfg.burst};
	end

	always_comb begin
		logic [32:0] old;
		logic [32:0] rdw;
		logic [31:0] wv;
		old    = '0;
		rdw    = '0;
		wv     = '0;
		s_next = s_reg;
		// Raw pins into sy1, sy1 into sy2; cleared flops read as a request while all channels are off
		s_next.sy1 = ext_req_n;
		s_next.sy2 = s_reg.sy1;

		if (s_axi_awvalid && s_axi_awready) begin
			s_next.aw_have = 1'h1;
			s_next.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			s_next.w_have = 1'h1;
			s_next.w_data = s_axi_wdata;
			s_next.w_strb = s_axi_wstrb;
		end
		if (s_reg.bvalid && s_axi_bready)
			s_next.bvalid = 1'h0;
		if (s_reg.aw_have && s_reg.w_have && !s_reg.bvalid) begin
			old            = rd_word(s_reg, s_reg.aw_addr);
			wv             = merge(old[31:0], s_reg.w_data, s_reg.w_strb);
			s_next.aw_have = 1'h0;
			s_next.w_have  = 1'h0;
			s_next.bvalid  = 1'h1;
			s_next.bresp   = old[32] ? RESP_OKAY : RESP_SLVERR;
			if (s_reg.aw_addr == ADDR_CTRL) begin
				s_next.ctrl_en = wv[CTRL_EN_BIT];
				s_next.ctrl_rr = wv[CTRL_RR_BIT];
			end
			if (s_reg.aw_addr == ADDR_STAT) begin
				wv          = merge(32'h0000_0000, s_reg.w_data, s_reg.w_strb);
				s_next.done = s_reg.done & ~wv[STAT_DONE_LSB +: NCH];
				s_next.err  = s_reg.err & ~wv[STAT_ERR_LSB +: NCH];
			end
			for (int i = 0; i < NCH; i++) begin
				if (s_reg.aw_addr == ch_addr(i))
					s_next.cfg[i] = dca_cfg_type'(wv[$bits(dca_cfg_type)-1:0]);
				if (s_reg.aw_addr == 8'(ch_addr(i) + ADDR_CNT_OFS))
					s_next.cnt[i] = wv[CNT_W-1:0];
			end
		end

		if (s_reg.rvalid && s_axi_rready)
			s_next.rvalid = 1'h0;
		if (s_axi_arvalid && s_axi_arready) begin
			rdw           = rd_word(s_reg, s_axi_araddr);
			s_next.rvalid = 1'h1;
			s_next.rdata  = rdw[31:0];
			s_next.rresp  = rdw[32] ? RESP_OKAY : RESP_SLVERR;
		end

		// Hardware sets after software clears, so a same-cycle event survives
		for (int i = 0; i < NCH; i++) begin
			if (s_reg.cfg[i].en && !legal[i])
				s_next.err[i] = 1'h1;
		end

		if (s_reg.arb == ARB_UNIT && unit_done) begin
			s_next.unit_valid = 1'h0;
			s_next.ack        = 2'h0;
			s_next.fin        = 1'h1;
		end
		if (fin_now) begin
			s_next.fin        = 1'h0;
			s_next.cnt[owner] = s_reg.cnt[owner] - CNT_W'(1);
			if (s_reg.cnt[owner] == CNT_W'(1))
				s_next.done[owner] = 1'h1;
			s_next.rr_ptr = 2'(owner + 2'h1);
			s_next.arb    = ARB_IDLE; // R12
		end
		if (go) begin
			s_next.arb        = ARB_UNIT;
			s_next.unit_valid = 1'h1;
			s_next.fin        = 1'h0;
			s_next.unit       = '{ch: go_ch, cfg: s_reg.cfg[go_ch]};
			for (int k = 0; k < 2; k++)
				s_next.ack[k] = go_ch == 2'(k) && s_reg.cfg[go_ch].req == SRC_EXT;
		end
		s_next.cpu_grant = s_next.arb == ARB_IDLE; // R11 R12
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			s_reg <= '0;
		else
			s_reg <= s_next;
	end

	assign s_axi_awready    = !s_reg.aw_have && !s_reg.bvalid;
	assign s_axi_wready     = !s_reg.w_have && !s_reg.bvalid;
	assign s_axi_bvalid     = s_reg.bvalid;
	assign s_axi_bresp      = s_reg.bresp;
	assign s_axi_arready    = !s_reg.rvalid;
	assign s_axi_rvalid     = s_reg.rvalid;
	assign s_axi_rdata      = s_reg.rdata;
	assign s_axi_rresp      = s_reg.rresp;
	assign unit_valid       = s_reg.unit_valid;
	assign unit_info        = s_reg.unit;
	assign cpu_grant        = s_reg.cpu_grant;
	assign transfer_ack_out = s_reg.ack;
	assign log_data         = dca_log_type'(fifo_out);

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	sequence s_fin;
		fin_now;
	endsequence

	sequence s_fixed_fin;
		fin_now && !s_reg.ctrl_rr;
	endsequence

	sequence s_rr_fin;
		fin_now && s_reg.ctrl_rr;
	endsequence

	property p_r1;
		unit_valid && (unit_info.cfg.src == EP_ACKDEV || unit_info.cfg.dst == EP_ACKDEV)
			|-> unit_info.cfg.req == SRC_EXT;
	endproperty
	a_r1: assert property (p_r1) // R1
		else $error("ack device unit started without external request");

	property p_r2;
		unit_valid && unit_info.cfg.src inside {EP_XMEM, EP_MMDEV}
			&& unit_info.cfg.dst inside {EP_XMEM, EP_MMDEV}
			|-> unit_info.cfg.req inside {SRC_EXT, SRC_AUTO, SRC_CMP_TIMER};
	endproperty
	a_r2: assert property (p_r2) // R2
		else $error("memory unit started by a peripheral port request");

	property p_r3;
		unit_valid && unit_info.cfg.req inside {SRC_IR, SRC_FSP, SRC_ADC}
			|-> unit_info.cfg.src == dca_ep_type'(unit_info.cfg.req + 3'h1)
			|| unit_info.cfg.dst == dca_ep_type'(unit_info.cfg.req + 3'h1);
	endproperty
	a_r3: assert property (p_r3) // R3
		else $error("peripheral request source is not an endpoint");

	property p_r4;
		unit_valid && unit_info.cfg.req inside {SRC_IR, SRC_FSP, SRC_ADC}
			|-> !unit_info.cfg.burst;
	endproperty
	a_r4: assert property (p_r4) // R4
		else $error("peripheral requested channel runs in burst");

	property p_r5;
		unit_valid && (unit_info.cfg.src >= EP_ONCHIP || unit_info.cfg.dst >= EP_ONCHIP)
			|-> unit_info.cfg.size != SZ_128;
	endproperty
	a_r5: assert property (p_r5) // R5
		else $error("on-chip register unit uses 128 bits");

	property p_r6;
		unit_valid && unit_info.cfg.req == SRC_EXT |-> unit_info.ch < 2'h2
			&& transfer_ack_out == (2'h1 << unit_info.ch);
	endproperty
	a_r6: assert property (p_r6) // R6
		else $error("external request started a channel above 1");

	property p_r7;
		s_fixed_fin ##0 (req_after[0] && owner != 2'h0 && (req_after & burst_v) != '0)
			|=> unit_valid && unit_info.ch == 2'h0 && !cpu_grant;
	endproperty
	a_r7: assert property (p_r7) // R7
		else $error("higher channel did not preempt the burst");

	property p_r8;
		go && !s_reg.ctrl_rr && (go_idle ? req_v[0] : req_after[0])
			|=> unit_valid && unit_info.ch == 2'h0;
	endproperty
	a_r8: assert property (p_r8) // R8
		else $error("channel 1 resumed while channel 0 still had work");

	property p_r9;
		s_rr_fin ##0 (owner == 2'h0 && req_after[1] && (req_after & burst_v) != '0)
			|=> unit_valid && unit_info.ch == 2'h1;
	endproperty
	a_r9: assert property (p_r9) // R9
		else $error("channel 1 not resumed after one channel 0 unit");

	property p_r10;
		s_rr_fin ##0 (owner == 2'h1 && req_after[0] && req_after[3:2] == 2'h0
			&& (req_after & burst_v) != '0) |=> unit_valid && unit_info.ch == 2'h0;
	endproperty
	a_r10: assert property (p_r10) // R10
		else $error("round-robin did not alternate back to channel 0");

	property p_r11;
		s_fin ##0 ((req_after & burst_v) != '0) |=> !cpu_grant && unit_valid;
	endproperty
	a_r11: assert property (p_r11) // R11
		else $error("bus went to the CPU while a burst channel was active");

	property p_r12;
		s_fin ##0 (req_after == '0) |=> cpu_grant && !unit_valid;
	endproperty
	a_r12: assert property (p_r12) // R12
		else $error("bus not returned to the CPU after the last unit");
endmodule
`default_nettype wire

/* dca_bus_model.sv */
// dca_bus_model.sv: system bus stand-in that finishes granted units and drains the log.
// Assumes unit_valid stands until the edge after unit_done; records owners in order.
`timescale 1ns/1ps
`default_nettype none
module dca_bus_model (
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	input  wire logic                  unit_valid,
	input  wire dca_pkg::dca_unit_type unit_info,
	output logic                       unit_done,
	input  wire logic [4:0]            dly,
	input  wire logic                  hold,
	output logic                       log_ready
);
	import dca_pkg::*;
	logic [1:0] order[$];
	logic [4:0] cnt;
	// Holding the log back lets the bench fill the record buffer
	assign log_ready = !hold;
	always @(posedge aclk) begin
		if (!aresetn) begin
			unit_done <= 1'b0;
			cnt <= 5'h00;
		end else if (unit_done) begin
			unit_done <= 1'b0;
			cnt <= 5'h00;
			order.push_back(unit_info.ch);
		end else if (unit_valid) begin
			cnt <= cnt + 5'h01;
			unit_done <= (cnt == dly - 5'h01);
		end
	end
endmodule
`default_nettype wire

/* tb_dma_channel_mode_arbiter.sv */
// tb_dma_channel_mode_arbiter.sv: self-checking bench of the channel mode arbiter.
// Assumes dca_bus_model answers units; registers are reached over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module tb_dma_channel_mode_arbiter;
	import dca_pkg::*;
	typedef struct packed {logic [1:0] ch; dca_cfg_type cfg; logic err;} dca_row_type;
	localparam dca_cfg_type BA = '{SZ_32, EP_XMEM, EP_XMEM, SRC_AUTO, 1'b1, 1'b1};
	localparam dca_cfg_type EC = '{SZ_8, EP_MMDEV, EP_ACKDEV, SRC_EXT, 1'b0, 1'b1};
	localparam dca_cfg_type TM = '{SZ_8, EP_XMEM, EP_ONCHIP, SRC_CMP_TIMER, 1'b0, 1'b1};
	localparam dca_row_type ROWS [10] = '{
		'{2'h0, '{SZ_128, EP_MMDEV, EP_ACKDEV, SRC_EXT, 1'b1, 1'b1}, 1'b0},
		'{2'h0, '{SZ_32, EP_MMDEV, EP_ACKDEV, SRC_AUTO, 1'b0, 1'b1}, 1'b1},
		'{2'h2, '{SZ_32, EP_XMEM, EP_ACKDEV, SRC_EXT, 1'b0, 1'b1}, 1'b1},
		'{2'h1, '{SZ_128, EP_MMDEV, EP_XMEM, SRC_CMP_TIMER, 1'b1, 1'b1}, 1'b0},
		'{2'h1, '{SZ_32, EP_XMEM, EP_IR, SRC_IR, 1'b0, 1'b1}, 1'b0},
		'{2'h1, '{SZ_32, EP_MMDEV, EP_XMEM, SRC_IR, 1'b0, 1'b1}, 1'b1},
		'{2'h1, '{SZ_32, EP_XMEM, EP_FSP, SRC_FSP, 1'b1, 1'b1}, 1'b1},
		'{2'h2, '{SZ_16, EP_ADC, EP_XMEM, SRC_ADC, 1'b0, 1'b1}, 1'b0},
		'{2'h3, '{SZ_128, EP_ONCHIP, EP_XMEM, SRC_AUTO, 1'b0, 1'b1}, 1'b1},
		'{2'h3, '{SZ_8, EP_XMEM, EP_ONCHIP, SRC_AUTO, 1'b0, 1'b1}, 1'b0}};
	logic         aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
	logic         s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, hold = 1'b0;
	logic [7:0]   s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0]  s_axi_wdata = 32'h0, s_axi_rdata;
	logic [1:0]   ext_req_n = 2'h3, s_axi_bresp, s_axi_rresp, transfer_ack_out;
	logic [4:0]   dly = 5'h14;
	logic         cmp_timer_req = 1'b0;
	logic [2:0]   periph_req = 3'h0;
	logic         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic         unit_valid, unit_done, cpu_grant, log_valid, log_ready;
	dca_unit_type unit_info;
	dca_log_type  log_data;
	int           num_errors = 0, checks_done = 0, cpu_n = 0, log_n = 0;

	dca_arbiter u_dut (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
		.s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_bvalid,
		.s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
		.s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .ext_req_n,
		.cmp_timer_req, .periph_req, .unit_valid, .unit_info, .unit_done,
		.cpu_grant, .transfer_ack_out, .log_valid, .log_ready, .log_data);
	dca_bus_model u_bus (.aclk, .aresetn, .unit_valid, .unit_info, .unit_done, .dly, .hold,
		.log_ready);

	initial forever #5 aclk = ~aclk;
	always @(posedge aclk) begin
		if (cpu_grant) cpu_n++;
		if (log_valid && log_ready) log_n++;
	end

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
	endtask
	task automatic waitq(input int k);
		for (int i = 0; i < 3000 && u_bus.order.size() < k; i++) @(posedge aclk);
	endtask
	// Channel 1 bursts alone first, channel 0 joins in the middle of its second unit
	task automatic arb(input logic [31:0] ctl, input int n0, input logic [11:0] exp, input int n);
		int c0;
		u_bus.order.delete();
		wr(ADDR_CTRL, ctl);
		wr(ADDR_CH_BASE + 8'h0C, 32'h3);
		wr(ADDR_CH_BASE + 8'h08, 32'(BA));
		// Error flags left by the legality rows would block the channel
		wr(ADDR_STAT, 32'hF00);
		waitq(1);
		c0 = cpu_n;
		wr(ADDR_CH_BASE + 8'h04, 32'(n0));
		wr(ADDR_CH_BASE, 32'(BA));
		waitq(n - 1);
		chk("cpu grant in burst", 32'h0, 32'(cpu_n - c0));
		waitq(n);
		repeat (3) @(posedge aclk);
		chk("cpu grant after", 32'h1, cpu_grant);
		for (int i = 0; i < n; i++) chk("owner", exp[2*i+:2], u_bus.order[i]);
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	initial begin
		#100us;
		num_errors++;
		print_verdict;
	end
	initial begin
		logic [31:0] d;
		logic [1:0] r;
		int c;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		chk("cpu_grant", 32'h1, cpu_grant);
		rd(8'hFC, d, r);
		chk("unmapped resp", RESP_SLVERR, r);
		wr(8'hFC, 32'h1);
		chk("unmapped write resp", RESP_SLVERR, s_axi_bresp);
		rd(ADDR_STAT, d, r);
		chk("status", 32'h0, d);
		wr(ADDR_CTRL, 32'h1);
		$display("test reset done");
		foreach (ROWS[i]) begin
			wr(8'(ADDR_CH_BASE + 8 * ROWS[i].ch), 32'(ROWS[i].cfg));
			wr(ADDR_STAT, 32'hF00);
			rd(ADDR_STAT, d, r);
			chk("cfg error", ROWS[i].err, d[STAT_ERR_LSB + ROWS[i].ch]);
		end
		$display("test legality done");
		wr(ADDR_CH_BASE + 8'h04, 32'h1);
		wr(ADDR_CH_BASE, 32'(EC));
		wr(ADDR_STAT, 32'hF00);
		ext_req_n <= 2'h2;
		for (int i = 0; i < 200 && !unit_valid; i++) @(posedge aclk);
		@(posedge aclk);
		chk("ack pins", 32'h1, transfer_ack_out);
		chk("unit channel", 32'h0, unit_info.ch);
		ext_req_n <= 2'h3;
		for (int i = 0; i < 200 && unit_valid; i++) @(posedge aclk);
		$display("test pin done");
		arb(32'h1, 2, 12'h105, 5);
		$display("test fixed done");
		arb(32'h3, 3, 12'h045, 6);
		$display("test round robin done");
		// A stalled log consumer must stop the arbiter, not drop records
		hold <= 1'b1;
		dly <= 5'h01;
		c = log_n;
		wr(ADDR_CH_BASE + 8'h04, 32'd20);
		repeat (300) @(posedge aclk);
		chk("stalled unit", 32'h0, unit_valid);
		rd(ADDR_CH_BASE + 8'h04, d, r);
		chk("units before stall", 32'd3, d);
		chk("log waiting", 32'h1, log_valid);
		chk("log channel", 32'h0, log_data.ch);
		hold <= 1'b0;
		for (int i = 0; i < 600 && log_n - c < 20; i++) @(posedge aclk);
		repeat (5) @(posedge aclk);
		chk("log records", 32'd20, 32'(log_n - c));
		$display("test log buffer done");
		// Timer and A/D requests run cycle-steal units on channels 3 and 2
		dly <= 5'h14;
		cmp_timer_req <= 1'b1;
		periph_req <= 3'h4;
		wr(ADDR_CH_BASE + 8'h18, 32'(TM));
		wr(ADDR_CH_BASE + 8'h1C, 32'h1);
		wr(ADDR_CH_BASE + 8'h14, 32'h2);
		for (int i = 0; i < 200 && !(unit_valid && unit_info.ch == 2'h2); i++) @(posedge aclk);
		for (int i = 0; i < 200 && unit_valid; i++) @(posedge aclk);
		chk("cpu after steal unit", 32'h1, cpu_grant);
		rd(ADDR_CH_BASE + 8'h14, d, r);
		chk("steal units left", 32'h1, d);
		for (int i = 0; i < 200 && !cpu_grant; i++) @(posedge aclk);
		rd(ADDR_STAT, d, r);
		chk("done flags", 32'hF, d[3:0]);
		$display("test request sources done");
		print_verdict;
	end
endmodule
`default_nettype wire
